// ---- rtl/prs_pkg.sv ----
// Package for the power-on reset sequencer: source codes, states, timing, carriers.
// Assumes a single 20 MHz system clock domain.
package prs_pkg;

	localparam int SYS_CLK_HZ = 20_000_000;
	localparam int CFG_WORD_W = 32;
	localparam int CFG_BYTES = 8;
	localparam int STRAP_W = 4;
	localparam logic [15:0] FLASH_BASE_ADDR = 16'h0000;
	localparam logic [15:0] FLASH_ADDR_STEP = 16'h0008;
	localparam logic [2:0] LAST_BYTE_IDX = 3'h7;
	localparam logic [2:0] LOW_LAST_IDX = 3'h3;
	// Straps decode: top bits pick the source, others ignored here
	localparam logic [1:0] SRC_I2C = 2'h0;
	localparam logic [1:0] SRC_LOCAL_BUS = 2'h1;
	localparam logic [1:0] SRC_HARD = 2'h2;
	// Hard-coded word values, arbitrary defaults
	localparam logic [31:0] HARD_CFG_LOW = 32'h0000_0000;
	localparam logic [31:0] HARD_CFG_HIGH = 32'h0000_0000;
	// Boot sequencer enable bit inside the high word
	localparam int BOOT_EN_BIT = 0;

	typedef enum logic [3:0] {
		PRS_IDLE,
		PRS_STRAP,
		PRS_LOAD_LOW,
		PRS_SYS_LOCK,
		PRS_LOAD_HIGH,
		PRS_CORE_LOCK,
		PRS_RELEASE,
		PRS_BOOT,
		PRS_RUN
	} prs_state_t;

	typedef struct packed {
		logic req;
		logic [1:0] src;
		logic [15:0] addr;
	} prs_fetch_t;

	typedef struct packed {
		logic [31:0] low;
		logic [31:0] high;
	} prs_cfg_t;

endpackage

// ---- rtl/prs_sequencer.sv ----
// Power-on reset sequencer: straps, two config words, PLL bring-up, hard reset release, boot.
// Assumes byte fetch answers (ack with data) come from I2C/local-bus engines outside this block.
// Function
// - Power-on reset held returns every register here to its default.
// - Straps captured at power-on reset release choose the word source.
// - Word fetch starts after capture; system PLL starts after low word.
// - Core PLL fed and started only after system PLL lock.
// - Hard reset held low until core lock and both words loaded.
// - Boot sequencer loads extra data from EEPROM or flash when enabled.
// - Top two of the four straps pick I2C, local bus or hard-coded words.
// - Two 32-bit words, low then high, read in full.
// - Flash fetch one byte per access from address 0x0 stepping 0x8.
// - Hard reset is open drain; device only pulls it low.
`timescale 1ns/100ps
module prs_sequencer
	import prs_pkg::*;
(
	// Clock and power-on reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Straps
	input wire logic [STRAP_W-1:0] cfg_strap,
	// Byte fetch port
	output prs_fetch_t fetch,
	input wire logic fetch_ack,
	input wire logic [7:0] fetch_data,
	// PLL control
	output logic sys_pll_en,
	input wire logic sys_pll_lock,
	output logic core_clk_gate,
	input wire logic core_pll_lock,
	// Hard reset pin, open drain
	input wire logic hard_reset_n_in,
	output logic hard_reset_n_out,
	output logic hard_reset_n_oe,
	// Boot sequencer
	output logic boot_start,
	input wire logic boot_done,
	// Status
	output prs_cfg_t cfg_words,
	output logic seq_done
);

	prs_state_t state_ff, nxt_state;
	logic [1:0] src_ff;
	logic [2:0] idx_ff;
	logic [15:0] addr_ff;
	logic [CFG_BYTES*8-1:0] bytes_ff;
	logic boot_req_ff;
	logic words_ok;

	// Source decode from the captured straps
	function automatic logic [1:0] decode_src(input logic [STRAP_W-1:0] s);
		logic [1:0] r;
		r = SRC_I2C;
		if (s[STRAP_W-1])
			r = SRC_HARD;
		else if (s[STRAP_W-2])
			r = SRC_LOCAL_BUS;
		return r;
	endfunction

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			PRS_IDLE: nxt_state = PRS_STRAP;
			PRS_STRAP: nxt_state = PRS_LOAD_LOW;
			PRS_LOAD_LOW: if (src_ff == SRC_HARD || (fetch_ack && idx_ff == LOW_LAST_IDX))
				nxt_state = PRS_SYS_LOCK;
			PRS_SYS_LOCK: if (sys_pll_lock)
				nxt_state = PRS_LOAD_HIGH;
			PRS_LOAD_HIGH: if (src_ff == SRC_HARD || (fetch_ack && idx_ff == LAST_BYTE_IDX))
				nxt_state = PRS_CORE_LOCK;
			PRS_CORE_LOCK: if (core_pll_lock)
				nxt_state = PRS_RELEASE;
			// Board may still hold the pin low; boot waits for it
			PRS_RELEASE: if (hard_reset_n_in)
				nxt_state = boot_req_ff ? PRS_BOOT : PRS_RUN;
			PRS_BOOT: if (boot_done)
				nxt_state = PRS_RUN;
			PRS_RUN: nxt_state = PRS_RUN;
			default: nxt_state = PRS_IDLE;
		endcase
	end

	// Whole sequence is defaults while power-on reset held
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_ff <= PRS_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Straps sampled by a clocked step after release, never under reset
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			src_ff <= SRC_I2C;
		end else if (state_ff == PRS_IDLE) begin
			src_ff <= decode_src(cfg_strap);
		end
	end

	// Byte gathering, low word first
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			idx_ff <= 3'h0;
			addr_ff <= FLASH_BASE_ADDR;
			bytes_ff <= '0;
		end else if (state_ff == PRS_STRAP && src_ff == SRC_HARD) begin
			bytes_ff <= {HARD_CFG_LOW, HARD_CFG_HIGH};
		end else if (fetch.req && fetch_ack) begin
			bytes_ff[(CFG_BYTES-1-idx_ff)*8 +: 8] <= fetch_data;
			idx_ff <= idx_ff + 3'h1;
			addr_ff <= addr_ff + FLASH_ADDR_STEP;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			boot_req_ff <= 1'b0;
		end else if (state_ff == PRS_CORE_LOCK) begin
			boot_req_ff <= bytes_ff[BOOT_EN_BIT];
		end
	end

	// One driver for the whole carrier
	assign fetch = '{
		req: src_ff != SRC_HARD && (state_ff == PRS_LOAD_LOW || state_ff == PRS_LOAD_HIGH),
		src: src_ff,
		addr: addr_ff
	};
	assign cfg_words = bytes_ff;

	// Clock gate for core PLL only after system lock
	assign sys_pll_en = state_ff inside {PRS_SYS_LOCK, PRS_LOAD_HIGH, PRS_CORE_LOCK, PRS_RELEASE,
		PRS_BOOT, PRS_RUN};
	assign core_clk_gate = state_ff inside {PRS_CORE_LOCK, PRS_RELEASE, PRS_BOOT, PRS_RUN};
	assign words_ok = state_ff inside {PRS_CORE_LOCK, PRS_RELEASE, PRS_BOOT, PRS_RUN};

	// Open drain: drive low only, pull-up gives the high level
	assign hard_reset_n_out = 1'b0;
	assign hard_reset_n_oe = !(state_ff inside {PRS_RELEASE, PRS_BOOT, PRS_RUN});
	assign boot_start = state_ff == PRS_RELEASE && boot_req_ff && hard_reset_n_in;
	assign seq_done = state_ff == PRS_RUN;

	property p_hard_reset_n_hold;
		@(posedge sys_clk) disable iff (!reset_n)
		$fell(hard_reset_n_oe) |-> $past(state_ff) == PRS_CORE_LOCK && $past(core_pll_lock) && words_ok;
	endproperty
	a_hard_reset_n_hold: assert property (p_hard_reset_n_hold) else $error("hard reset released early");

	property p_core_after_sys;
		@(posedge sys_clk) disable iff (!reset_n)
		$rose(core_clk_gate) |-> $past(sys_pll_lock) && sys_pll_en;
	endproperty
	a_core_after_sys: assert property (p_core_after_sys) else $error("core clock before sys lock");

	property p_sys_after_low;
		@(posedge sys_clk) disable iff (!reset_n)
		$rose(sys_pll_en) |-> $past(state_ff) == PRS_LOAD_LOW;
	endproperty
	a_sys_after_low: assert property (p_sys_after_low) else $error("sys pll before low word");

	property p_addr_step;
		@(posedge sys_clk) disable iff (!reset_n)
		fetch.req && fetch_ack |=> fetch.addr == $past(fetch.addr) + FLASH_ADDR_STEP;
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("flash address step wrong");

	property p_drive_low;
		@(posedge sys_clk) disable iff (!reset_n)
		hard_reset_n_oe |-> hard_reset_n_out == 1'b0;
	endproperty
	a_drive_low: assert property (p_drive_low) else $error("hard reset driven high");

	property p_first_addr;
		@(posedge sys_clk) disable iff (!reset_n)
		state_ff == PRS_STRAP |-> fetch.addr == FLASH_BASE_ADDR;
	endproperty
	a_first_addr: assert property (p_first_addr) else $error("fetch not from base");

	property p_order;
		@(posedge sys_clk) disable iff (!reset_n)
		state_ff == PRS_CORE_LOCK |-> $past(state_ff) inside {PRS_LOAD_HIGH, PRS_CORE_LOCK};
	endproperty
	a_order: assert property (p_order) else $error("step skipped");

	property p_reset_start;
		@(posedge sys_clk)
		$rose(reset_n) |-> state_ff == PRS_IDLE && hard_reset_n_oe;
	endproperty
	a_reset_start: assert property (p_reset_start) else $error("not at default after reset");

	property p_strap_cap;
		@(posedge sys_clk) disable iff (!reset_n)
		state_ff == PRS_IDLE |=> src_ff == decode_src($past(cfg_strap));
	endproperty
	a_strap_cap: assert property (p_strap_cap) else $error("straps not captured");

	property p_low_count;
		@(posedge sys_clk) disable iff (!reset_n)
		$rose(sys_pll_en) && fetch.src != SRC_HARD |-> $past(idx_ff) == LOW_LAST_IDX;
	endproperty
	a_low_count: assert property (p_low_count) else $error("sys pll before four low bytes");

	property p_high_count;
		@(posedge sys_clk) disable iff (!reset_n)
		$rose(core_clk_gate) && fetch.src != SRC_HARD |-> $past(idx_ff) == LAST_BYTE_IDX;
	endproperty
	a_high_count: assert property (p_high_count) else $error("high word not read in full");

	property p_core_wait;
		@(posedge sys_clk) disable iff (!reset_n)
		state_ff == PRS_CORE_LOCK && !core_pll_lock |=> hard_reset_n_oe;
	endproperty
	a_core_wait: assert property (p_core_wait) else $error("hard reset released before core lock");

	property p_boot_once;
		@(posedge sys_clk) disable iff (!reset_n)
		boot_start |=> !boot_start;
	endproperty
	a_boot_once: assert property (p_boot_once) else $error("boot start longer than one cycle");

endmodule // prs_sequencer

// ---- dv/prs_board.sv ----
// Board model: byte source, both PLLs and boot sequencer.
// Assumes the bench drives reset and straps.
`timescale 1ns/100ps
module prs_board
	import prs_pkg::*;
(
	// Clock
	input wire logic sys_clk,
	// From device
	input wire prs_fetch_t fetch,
	input wire logic sys_pll_en,
	input wire logic core_clk_gate,
	input wire logic boot_start,
	// To device
	output logic fetch_ack,
	output logic [7:0] fetch_data,
	output logic sys_pll_lock,
	output logic core_pll_lock,
	output logic boot_done
);
	int s_cnt = 0;
	int c_cnt = 0;
	logic [7:0] cyc_ff = 8'h00;
	initial fetch_ack = 1'b0;
	initial boot_done = 1'b0;
	// Ack every other cycle while fetch.req is high; no ack follows the last byte
	always @(posedge sys_clk) begin
		cyc_ff <= #1 cyc_ff + 8'h01;
		s_cnt <= #1 sys_pll_en ? s_cnt + 1 : 0;
		c_cnt <= #1 core_clk_gate ? c_cnt + 1 : 0;
		fetch_ack <= #1 fetch.req & ~fetch_ack;
		boot_done <= #1 boot_start;
	end
	// Unqualified data is junk that moves each cycle
	assign fetch_data = fetch_ack ? (8'hA0 | {4'h0, fetch.addr[6:3]}) : cyc_ff;
	assign sys_pll_lock = s_cnt > 5;
	assign core_pll_lock = c_cnt > 3;
endmodule // prs_board

// ---- dv/power_on_reset_sequencer_test.sv ----
// Bench: strap table, order monitor, mid-run reset.
// Assumes prs_board answers fetches, locks and boot.
`timescale 1ns/100ps
module power_on_reset_sequencer_test;
	import prs_pkg::*;
	typedef struct {logic [3:0] s; logic [1:0] src; logic [63:0] w; int b;} prs_row_t;
	localparam logic [63:0] W = 64'hA0A1_A2A3_A4A5_A6A7;
	localparam logic [63:0] H = {HARD_CFG_LOW, HARD_CFG_HIGH};
	localparam int HB = int'(HARD_CFG_HIGH[BOOT_EN_BIT]);
	prs_row_t rows [5] = '{'{4'h0, SRC_I2C, W, 1}, '{4'h4, SRC_LOCAL_BUS, W, 1},
		'{4'h7, SRC_LOCAL_BUS, W, 1}, '{4'h8, SRC_HARD, H, HB}, '{4'hF, SRC_HARD, H, HB}};
	logic sys_clk = 0, reset_n = 0, hard_reset_n_in, sys_pll_lock, core_pll_lock;
	logic fetch_ack, boot_done, sys_pll_en, core_clk_gate, hard_reset_n_out;
	logic hard_reset_n_oe, boot_start, seq_done, hard, sl, cl;
	logic ext_hold = 1'b0;
	logic [3:0] cfg_strap = 4'h0;
	logic [7:0] fetch_data;
	prs_fetch_t fetch;
	prs_cfg_t cfg_words;
	int fails = 0, num_checks = 0, taken = 0, boots = 0;
	always #25 sys_clk = ~sys_clk;
	assign hard_reset_n_in = (hard_reset_n_oe ? hard_reset_n_out : 1'b1) & !ext_hold;
	assign hard = fetch.src === SRC_HARD;
	prs_sequencer u_prs_sequencer(.sys_clk, .reset_n, .cfg_strap, .fetch, .fetch_ack,
		.fetch_data, .sys_pll_en, .sys_pll_lock, .core_clk_gate, .core_pll_lock,
		.hard_reset_n_in, .hard_reset_n_out, .hard_reset_n_oe, .boot_start, .boot_done,
		.cfg_words, .seq_done);
	prs_board u_prs_board(.sys_clk, .fetch, .sys_pll_en, .core_clk_gate, .boot_start,
		.fetch_ack, .fetch_data, .sys_pll_lock, .core_pll_lock, .boot_done);
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Order monitor on pre-edge values
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			{taken, boots, sl, cl} = '0;
		end else begin
			if (fetch.req) check(fetch.addr, 64'(taken * 8));
			if (sys_pll_en) check(taken >= 4 || hard, 1);
			if (core_clk_gate) check(sl && (taken == 8 || hard), 1);
			if (!hard_reset_n_oe) check(cl && (taken == 8 || hard), 1);
			check(hard_reset_n_out, 0);
			taken += fetch.req && fetch_ack;
			boots += boot_start;
			sl |= sys_pll_lock && sys_pll_en;
			cl |= core_pll_lock && core_clk_gate;
		end
	end
	task automatic hold_reset(input logic [3:0] s);
		#1 reset_n = 0;
		cfg_strap = s;
		repeat (32) @(posedge sys_clk);
		check({hard_reset_n_oe, sys_pll_en, core_clk_gate, fetch.req, seq_done}, 5'h10);
		check(fetch.addr, 64'(FLASH_BASE_ADDR));
		check(cfg_words, 0);
		#1 reset_n = 1;
	endtask
	task automatic wait_done();
		for (int k = 0; k < 300 && seq_done !== 1'b1; k++) @(posedge sys_clk);
		check(seq_done, 1);
	endtask
	initial begin
		foreach (rows[i]) begin
			hold_reset(rows[i].s);
			repeat (3) @(posedge sys_clk);
			#1 cfg_strap = ~rows[i].s;
			wait_done();
			check(fetch.src, rows[i].src);
			check(cfg_words, rows[i].w);
			check(boots, rows[i].b);
			check(hard_reset_n_in, 1);
			$display("row %0d done", i);
		end
		// Reset in mid-load must restart from byte zero
		hold_reset(4'h4);
		repeat (8) @(posedge sys_clk);
		hold_reset(4'h0);
		// Board keeps hard reset low past the device's own release
		ext_hold = 1'b1;
		repeat (60) @(posedge sys_clk);
		check(seq_done, 0);
		check(hard_reset_n_oe, 0);
		check(boots, 0);
		#1 ext_hold = 1'b0;
		wait_done();
		check(cfg_words, W);
		check(boots, 1);
		$display("mid-run reset done");
		finish_test();
	end
	// Whole run takes about 430 cycles; the 6000-cycle limit allows about fourteen times that
	initial begin
		#(50 * 6000);
		fails++;
		finish_test();
	end
endmodule // power_on_reset_sequencer_test
